// file: kms_consts.svh
// Constants for the keypad matrix scanner: timing, layout, opcodes and reset values.
// Summary of operation
// - Full matrix scan repeats every 21.3 ms.
// - Selected row driven low; low column means closed.
// - Eight row outputs, sixteen column inputs, 128 keys.
// - Ready key code pulses strobe as host interrupt.
// - Repeating keys resend code while held.
// - Slow repeat starts 470 ms after first strobe.
// - Selected keys go fast after six slow repeats.
// - Host command request sets acknowledging flag flip-flop.
// - Busy shown until command processing finishes.
// - Clock divider tick starts each row sense pass.
// - Rollover: new key forwarded while others held.
// - Position keys held together reported as combination.
// - Power-up test lights all LEDs and beeper.
// - Static LEDs: key LED follows key, background lit.
// - Beeper static, timing and duration by command.
// - Four trackball pulse trains sensed and reported.
`ifndef KMS_CONSTS_SVH
`define KMS_CONSTS_SVH
`define KMS_CLK_NS 8
`define KMS_ROWS 8
`define KMS_COLS 16
`define KMS_SCAN_US 21300
`define KMS_ROW_CYC ((`KMS_SCAN_US * 1000 / `KMS_CLK_NS) / `KMS_ROWS)
`define KMS_SLOW_START_MS 470
`define KMS_SLOW_START_CYC (`KMS_SLOW_START_MS * 1000000 / `KMS_CLK_NS)
`define KMS_SLOW_MS 100
`define KMS_SLOW_CYC (`KMS_SLOW_MS * 1000000 / `KMS_CLK_NS)
`define KMS_FAST_MS 33
`define KMS_FAST_CYC (`KMS_FAST_MS * 1000000 / `KMS_CLK_NS)
`define KMS_FAST_AFTER 3'h6
`define KMS_LAMP_MS 500
`define KMS_LAMP_CYC (`KMS_LAMP_MS * 1000000 / `KMS_CLK_NS)
`define KMS_BEEP_UNIT_MS 10
`define KMS_BEEP_UNIT_CYC (`KMS_BEEP_UNIT_MS * 1000000 / `KMS_CLK_NS)
`define KMS_STB_NS 1000
`define KMS_STB_CYC (`KMS_STB_NS / `KMS_CLK_NS)
`define KMS_GAP_NS 1000
`define KMS_GAP_CYC (`KMS_GAP_NS / `KMS_CLK_NS)
`define KMS_FIFO_DEPTH 16
`define KMS_CODE_W 8
`define KMS_OP_LED_LO 4'h1
`define KMS_OP_LED_HI 4'h2
`define KMS_OP_BEEP 4'h3
`define KMS_OP_BEEP_OFF 4'h4
`define KMS_PIN_RST 34'h0_0000_ffff
`define KMS_LED_ON 16'hffff
`define KMS_RPT_KEYS 128'h0000_0000_0000_0000_0000_0000_00ff_ffff
`define KMS_FAST_KEYS 128'h0000_0000_0000_0000_0000_0000_0000_00ff
`define KMS_POS_KEYS 128'h0000_0000_0000_0000_0000_0000_0000_000f
`endif

// file: kms_pkg.sv
// Types shared by the keypad matrix scanner.
package kms_pkg;
  typedef enum logic [1:0] {KMS_LAMP, KMS_IDLE, KMS_EXEC} kms_state_e;
endpackage

// file: kms_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module kms_fifo #(
  parameter int W = 8,
  parameter int D = 16
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic full;
  logic empty;
  assign empty = (wr_ff == rd_ff);
  assign full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ff[AW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule // kms_fifo
`default_nettype wire

// file: kms_keypad_matrix_scanner.sv
// Keypad matrix scanner: row scan, debounce, repeat, host strobe, commands, LEDs, beeper, trackball.
`timescale 1ns/1ps
`default_nettype none
`include "kms_consts.svh"
module kms_keypad_matrix_scanner
  import kms_pkg::*;
#(
  parameter int unsigned ROW_CYC = `KMS_ROW_CYC,
  parameter int unsigned SLOW_START_CYC = `KMS_SLOW_START_CYC,
  parameter int unsigned SLOW_CYC = `KMS_SLOW_CYC,
  parameter int unsigned FAST_CYC = `KMS_FAST_CYC,
  parameter int unsigned LAMP_CYC = `KMS_LAMP_CYC,
  parameter int unsigned BEEP_UNIT_CYC = `KMS_BEEP_UNIT_CYC,
  parameter logic [127:0] RPT_KEYS = `KMS_RPT_KEYS,
  parameter logic [127:0] FAST_KEYS = `KMS_FAST_KEYS,
  parameter logic [127:0] POS_KEYS = `KMS_POS_KEYS
)(
  input wire logic clk,
  input wire logic rstn,
  output logic [7:0] row_drive_n,
  input wire logic [15:0] col_sense_n,
  input wire logic [3:0] trackball_in,
  input wire logic cmd_strobe,
  input wire logic [11:0] cmd_data,
  input wire logic host_hold,
  output logic cmd_busy,
  output logic host_keyboard_irq_level,
  output logic [7:0] key_code,
  output logic trk_strobe,
  output logic [3:0] trk_dir,
  output logic [127:0] key_led,
  output logic [15:0] host_led,
  output logic [15:0] bg_led,
  output logic beeper
);
  localparam logic [31:0] STB_CYC = 32'(`KMS_STB_CYC);
  localparam logic [31:0] GAP_CYC = 32'(`KMS_GAP_CYC);

  // Pins from outside pass three flops; a change counts once stages two and three agree.
  logic [33:0] pins;
  logic [33:0] s1_ff;
  logic [33:0] s2_ff;
  logic [33:0] s3_ff;
  logic [33:0] flt_ff;
  assign pins = {cmd_data, host_hold, cmd_strobe, trackball_in, col_sense_n};
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_ff <= `KMS_PIN_RST;
      s2_ff <= `KMS_PIN_RST;
      s3_ff <= `KMS_PIN_RST;
      flt_ff <= `KMS_PIN_RST;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= (s2_ff & s3_ff) | (flt_ff & (s2_ff | s3_ff));
    end
  end

  // Row slot divider; eight slots make one full scan.
  logic [31:0] div_ff;
  logic row_tick;
  logic [2:0] row_ff;
  logic [7:0] drv_ff;
  assign row_tick = (div_ff == ROW_CYC - 1);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_ff <= '0;
      row_ff <= '0;
      drv_ff <= 8'hfe;
    end else if (row_tick) begin
      div_ff <= '0;
      row_ff <= row_ff + 3'h1;
      drv_ff <= ~(8'h01 << (row_ff + 3'h1));
    end else begin
      div_ff <= div_ff + 32'h1;
    end
  end
  assign row_drive_n = drv_ff;

  // Column sample at the end of each row slot, with two-scan debounce.
  logic [15:0] pressed;
  logic [15:0] prev_ff [8];
  logic [15:0] deb_ff [8];
  logic [15:0] newm;
  logic [127:0] deb_flat;
  assign pressed = ~flt_ff[15:0];
  assign newm = pressed & prev_ff[row_ff] & ~deb_ff[row_ff];
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int r = 0; r < 8; r++) begin
        prev_ff[r] <= '0;
        deb_ff[r] <= '0;
      end
    end else if (row_tick) begin
      prev_ff[row_ff] <= pressed;
      if (pressed == prev_ff[row_ff]) begin
        deb_ff[row_ff] <= pressed;
      end
    end
  end
  genvar gr;
  generate
    for (gr = 0; gr < 8; gr++) begin : g_flat
      assign deb_flat[gr*16 +: 16] = deb_ff[gr];
    end
  endgenerate

  // Pending new presses; a pointer walks them into the FIFO.
  logic [127:0] pend_ff;
  logic [6:0] ptr_ff;
  logic [127:0] set_vec;
  logic [127:0] clr_vec;
  logic fifo_in_ready;
  logic push_new;
  logic rpt_push;
  logic combo;
  assign set_vec = row_tick ? ({112'h0, newm} << {row_ff, 4'h0}) : '0;
  assign clr_vec = push_new ? (128'h1 << ptr_ff) : '0;
  assign push_new = pend_ff[ptr_ff] && fifo_in_ready && !rpt_push;
  assign combo = POS_KEYS[ptr_ff] && |(deb_flat & POS_KEYS & ~(128'h1 << ptr_ff));
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_ff <= '0;
      ptr_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~clr_vec) | set_vec;
      if (!pend_ff[ptr_ff] || push_new) begin
        ptr_ff <= ptr_ff + 7'h1;
      end
    end
  end

  // Auto-repeat of the most recent new key, when that key is a repeating key.
  logic rpt_on_ff;
  logic [6:0] rpt_key_ff;
  logic [31:0] rpt_tmr_ff;
  logic [2:0] rpt_n_ff;
  logic [2:0] nxt_rpt_n;
  assign rpt_push = rpt_on_ff && rpt_tmr_ff == '0 && deb_flat[rpt_key_ff] && fifo_in_ready;
  assign nxt_rpt_n = (rpt_n_ff == `KMS_FAST_AFTER) ? rpt_n_ff : rpt_n_ff + 3'h1;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rpt_on_ff <= 1'b0;
      rpt_key_ff <= '0;
      rpt_tmr_ff <= '0;
      rpt_n_ff <= '0;
    end else if (push_new) begin
      rpt_on_ff <= RPT_KEYS[ptr_ff];
      rpt_key_ff <= ptr_ff;
      rpt_tmr_ff <= SLOW_START_CYC - 1;
      rpt_n_ff <= '0;
    end else if (rpt_on_ff && !deb_flat[rpt_key_ff]) begin
      rpt_on_ff <= 1'b0;
    end else if (rpt_push) begin
      rpt_n_ff <= nxt_rpt_n;
      if (FAST_KEYS[rpt_key_ff] && nxt_rpt_n == `KMS_FAST_AFTER) begin
        rpt_tmr_ff <= FAST_CYC - 1;
      end else begin
        rpt_tmr_ff <= SLOW_CYC - 1;
      end
    end else if (rpt_on_ff && rpt_tmr_ff != '0) begin
      rpt_tmr_ff <= rpt_tmr_ff - 32'h1;
    end
  end

  // Key code queue toward the host.
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_in_data;
  logic [7:0] fifo_out_data;
  assign fifo_in_data = rpt_push ? {1'b0, rpt_key_ff} : {combo, ptr_ff};
  kms_fifo #(
    .W(`KMS_CODE_W),
    .D(`KMS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(rpt_push || push_new),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Host strobe: one pulse per code, then a quiet gap; the host may hold off delivery.
  kms_state_e st_ff;
  logic [31:0] stb_ff;
  logic [31:0] nxt_stb;
  logic irq_ff;
  logic [7:0] code_ff;
  assign fifo_pop = fifo_out_valid && !flt_ff[21] && stb_ff == '0 && st_ff != KMS_LAMP;
  assign nxt_stb = fifo_pop ? STB_CYC + GAP_CYC : (stb_ff != '0 ? stb_ff - 32'h1 : '0);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stb_ff <= '0;
      irq_ff <= 1'b0;
      code_ff <= '0;
    end else begin
      stb_ff <= nxt_stb;
      irq_ff <= nxt_stb > GAP_CYC;
      if (fifo_pop) begin
        code_ff <= fifo_out_data;
      end
    end
  end
  assign host_keyboard_irq_level = irq_ff;
  assign key_code = code_ff;

  // Trackball: a rising edge on any direction is reported with a one-cycle strobe.
  logic [3:0] trk_prev_ff;
  logic [3:0] trk_rise;
  logic trk_ff;
  logic [3:0] trk_dir_ff;
  assign trk_rise = flt_ff[19:16] & ~trk_prev_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trk_prev_ff <= '0;
      trk_ff <= 1'b0;
      trk_dir_ff <= '0;
    end else begin
      trk_prev_ff <= flt_ff[19:16];
      trk_ff <= |trk_rise;
      if (|trk_rise) begin
        trk_dir_ff <= trk_rise;
      end
    end
  end
  assign trk_strobe = trk_ff;
  assign trk_dir = trk_dir_ff;

  // Command flag, power-up lamp test and command execution.
  logic str_prev_ff;
  logic flag_ff;
  logic [11:0] cmd_ff;
  logic [31:0] lamp_ff;
  logic [31:0] beep_ff;
  logic [15:0] hled_ff;
  logic [127:0] kled_ff;
  logic bg_ff;
  logic beeper_ff;
  logic take;
  assign take = st_ff == KMS_IDLE && flag_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      str_prev_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      str_prev_ff <= flt_ff[20];
      if (flt_ff[20] && !str_prev_ff) begin
        flag_ff <= 1'b1;
      end else if (take) begin
        flag_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= KMS_LAMP;
      lamp_ff <= LAMP_CYC - 1;
      cmd_ff <= '0;
    end else begin
      unique case (st_ff)
        KMS_LAMP: begin
          lamp_ff <= lamp_ff - 32'h1;
          if (lamp_ff == '0) begin
            st_ff <= KMS_IDLE;
          end
        end
        KMS_IDLE: begin
          if (take) begin
            cmd_ff <= flt_ff[33:22];
            st_ff <= KMS_EXEC;
          end
        end
        KMS_EXEC: begin
          st_ff <= KMS_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hled_ff <= `KMS_LED_ON;
      beep_ff <= '0;
    end else if (st_ff == KMS_LAMP && lamp_ff == '0) begin
      hled_ff <= '0;
    end else if (st_ff == KMS_EXEC && cmd_ff[11:8] == `KMS_OP_LED_LO) begin
      hled_ff[7:0] <= cmd_ff[7:0];
    end else if (st_ff == KMS_EXEC && cmd_ff[11:8] == `KMS_OP_LED_HI) begin
      hled_ff[15:8] <= cmd_ff[7:0];
    end else if (st_ff == KMS_EXEC && cmd_ff[11:8] == `KMS_OP_BEEP) begin
      beep_ff <= 32'(cmd_ff[7:0] * BEEP_UNIT_CYC);
    end else if (st_ff == KMS_EXEC && cmd_ff[11:8] == `KMS_OP_BEEP_OFF) begin
      beep_ff <= '0;
    end else if (beep_ff != '0) begin
      beep_ff <= beep_ff - 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      kled_ff <= '1;
      bg_ff <= 1'b0;
      beeper_ff <= 1'b0;
    end else begin
      kled_ff <= (st_ff == KMS_LAMP) ? '1 : deb_flat;
      bg_ff <= 1'b1;
      beeper_ff <= st_ff == KMS_LAMP || beep_ff != '0;
    end
  end
  assign cmd_busy = flag_ff || st_ff != KMS_IDLE;
  assign host_led = hled_ff;
  assign key_led = kled_ff;
  assign bg_led = {16{bg_ff}};
  assign beeper = beeper_ff;
endmodule // kms_keypad_matrix_scanner
`default_nettype wire

// file: kms_properties.sv
// Concurrent checks on the keypad matrix scanner ports.
`timescale 1ns/1ps
`default_nettype none
module kms_properties #(
  parameter int unsigned ROW_CYC = 20
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] row_drive_n,
  input wire logic [3:0] trackball_in,
  input wire logic cmd_strobe,
  input wire logic cmd_busy,
  input wire logic host_keyboard_irq_level,
  input wire logic [7:0] key_code,
  input wire logic trk_strobe,
  input wire logic [3:0] trk_dir,
  input wire logic [127:0] key_led,
  input wire logic [15:0] host_led,
  input wire logic [15:0] bg_led,
  input wire logic beeper
);
  // The row slot counter is as wide as the slot length so the full-length divider fits.
  logic [31:0] row_cnt_ff;
  logic [15:0] hi_cnt_ff, lo_cnt_ff;
  logic row_seen_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      row_cnt_ff <= '0;
      row_seen_ff <= 1'b0;
    end else if ($changed(row_drive_n)) begin
      row_cnt_ff <= '0;
      row_seen_ff <= 1'b1;
    end else begin
      row_cnt_ff <= row_cnt_ff + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn || !host_keyboard_irq_level) hi_cnt_ff <= '0;
    else hi_cnt_ff <= hi_cnt_ff + 16'h1;
  end
  always_ff @(posedge clk) begin
    if (!rstn || host_keyboard_irq_level) lo_cnt_ff <= '0;
    else if (lo_cnt_ff != 16'hffff) lo_cnt_ff <= lo_cnt_ff + 16'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_lamp; (host_led == 16'hffff && key_led == '1) [*8]; endsequence
  sequence s_beep; ##1 beeper [*8]; endsequence
  property p_one_row; $onehot(~row_drive_n); endproperty
  a_one_row: assert property (p_one_row) else $error("more than one row driven");
  property p_row_step; $changed(row_drive_n) |-> {row_drive_n[0], row_drive_n[7:1]} == $past(row_drive_n); endproperty
  a_row_step: assert property (p_row_step) else $error("row order broken");
  property p_row_time; $changed(row_drive_n) && row_seen_ff |-> row_cnt_ff == ROW_CYC - 1; endproperty
  a_row_time: assert property (p_row_time) else $error("row slot length wrong");
  property p_stb_len; $fell(host_keyboard_irq_level) |-> hi_cnt_ff == 16'd125; endproperty
  a_stb_len: assert property (p_stb_len) else $error("key strobe length wrong");
  property p_stb_gap; $rose(host_keyboard_irq_level) |-> lo_cnt_ff >= 16'd125; endproperty
  a_stb_gap: assert property (p_stb_gap) else $error("key strobe gap too short");
  property p_code; $changed(key_code) |-> $rose(host_keyboard_irq_level); endproperty
  a_code: assert property (p_code) else $error("key code changed without strobe");
  property p_busy_on; $rose(cmd_strobe) && !cmd_busy |-> ##[1:8] cmd_busy; endproperty
  a_busy_on: assert property (p_busy_on) else $error("command not flagged");
  property p_busy_off; $rose(cmd_busy) |-> ##[1:8] !cmd_busy; endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy did not end");
  property p_lamp; $rose(rstn) |-> s_lamp and s_beep; endproperty
  a_lamp: assert property (p_lamp) else $error("power-up lamp test missing");
  property p_bg; rstn && $past(rstn) |-> bg_led == 16'hffff; endproperty
  a_bg: assert property (p_bg) else $error("background leds dark");
  property p_trk; $rose(trackball_in[2]) |-> ##[3:8] (trk_strobe && trk_dir[2]); endproperty
  a_trk: assert property (p_trk) else $error("trackball motion not reported");
endmodule // kms_properties
bind kms_keypad_matrix_scanner kms_properties #(.ROW_CYC(ROW_CYC)) kms_properties_i (.clk, .rstn, .row_drive_n,
  .trackball_in, .cmd_strobe, .cmd_busy, .host_keyboard_irq_level, .key_code, .trk_strobe, .trk_dir, .key_led,
  .host_led, .bg_led, .beeper);
`default_nettype wire

// file: kms_host_model.sv
// Host side model: issues commands under the busy flag and collects key strobes.
`timescale 1ns/1ps
`default_nettype none
module kms_host_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_busy,
  input wire logic host_keyboard_irq_level,
  input wire logic [7:0] key_code,
  output logic cmd_strobe,
  output logic [11:0] cmd_data,
  output logic host_hold
);
  logic irq_q = 1'b0;
  logic stall = 1'b0;
  logic [7:0] code_q[$];
  int time_q[$];
  int cyc = 0;
  initial begin
    cmd_strobe = 1'b0;
    cmd_data = 12'h000;
    host_hold = 1'b0;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_q <= host_keyboard_irq_level;
    host_hold <= stall;
    if (rstn && host_keyboard_irq_level && !irq_q) begin
      code_q.push_back(key_code);
      time_q.push_back(cyc);
    end
  end
  task automatic send(input logic [3:0] op, input logic [7:0] arg);
    int n;
    n = 0;
    while (cmd_busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    cmd_data <= {op, arg};
    cmd_strobe <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_busy !== 1'b1 && n < 1020);
    cmd_strobe <= 1'b0;
    while (cmd_busy !== 1'b0 && n < 1040) begin
      @(posedge clk);
      n++;
    end
  endtask
endmodule // kms_host_model
`default_nettype wire

// file: testbench.sv
// Self-checking testbench for the keypad matrix scanner.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SS = 600;
  localparam int SL = 300;
  localparam int FA = 260;
  logic clk = 0;
  logic rstn = 0;
  logic [127:0] keys = '0;
  logic [15:0] col_sense_n = 16'hffff;
  logic [3:0] trackball_in = 4'h0;
  logic cmd_strobe, cmd_busy, irq, trk_strobe, beeper, host_hold;
  logic [11:0] cmd_data;
  logic [7:0] row_drive_n, key_code;
  logic [3:0] trk_dir;
  logic [127:0] key_led;
  logic [15:0] host_led, bg_led;
  int fail_count = 0;
  int compares = 0;
  always #4 clk = ~clk;
  kms_keypad_matrix_scanner #(.ROW_CYC(20), .SLOW_START_CYC(SS), .SLOW_CYC(SL), .FAST_CYC(FA), .LAMP_CYC(50),
    .BEEP_UNIT_CYC(10)) kms_keypad_matrix_scanner_i (.clk, .rstn, .row_drive_n, .col_sense_n, .trackball_in,
    .cmd_strobe, .cmd_data, .host_hold, .cmd_busy, .host_keyboard_irq_level(irq), .key_code, .trk_strobe,
    .trk_dir, .key_led, .host_led, .bg_led, .beeper);
  kms_host_model kms_host_model_i (.clk, .rstn, .cmd_busy, .host_keyboard_irq_level(irq), .key_code,
    .cmd_strobe, .cmd_data, .host_hold);
  // Closed switches pull their column low only while their row is driven.
  always @(posedge clk) begin
    for (int r = 0; r < 8; r++) if (!row_drive_n[r]) col_sense_n <= ~keys[r*16 +: 16];
  end
  function automatic int nc();
    return kms_host_model_i.code_q.size();
  endfunction
  function automatic logic [7:0] cd(input int i);
    return kms_host_model_i.code_q[i];
  endfunction
  task automatic check(input string what, input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hk(input int k, input logic v);
    keys[k] <= v;
    repeat (400) @(posedge clk);
  endtask
  task automatic wc(input int n);
    for (int k = 0; k < 6000 && nc() < n; k++) @(posedge clk);
  endtask
  task automatic cmd(input logic [3:0] o, input logic [7:0] a);
    kms_host_model_i.send(o, a);
    repeat (4) @(posedge clk);
  endtask
  task automatic t_lamp();
    check("lamp host_led", host_led, 16'hffff);
    check("lamp beeper", beeper, 1'b1);
    check("bg_led", bg_led, 16'hffff);
    repeat (60) @(posedge clk);
    check("busy after lamp", cmd_busy, 1'b0);
    check("host_led after lamp", host_led, 16'h0);
  endtask
  task automatic t_cmd();
    cmd(4'h1, 8'ha5);
    cmd(4'h2, 8'h3c);
    check("host_led", host_led, 16'h3ca5);
    cmd(4'h7, 8'h00);
    check("unknown op", host_led, 16'h3ca5);
    cmd(4'h3, 8'h02);
    check("beep on", beeper, 1'b1);
    repeat (20) @(posedge clk);
    check("beep end", beeper, 1'b0);
    cmd(4'h3, 8'h09);
    check("long beep", beeper, 1'b1);
    cmd(4'h4, 8'h00);
    check("beep off", beeper, 1'b0);
  endtask
  task automatic t_key();
    int n;
    n = nc();
    hk(37, 1'b1);
    wc(n + 1);
    check("key code", cd(n), 8'h25);
    check("key led on", key_led[37], 1'b1);
    hk(37, 1'b0);
    check("key led off", key_led[37], 1'b0);
    keys[38] <= 1'b1;
    repeat (60) @(posedge clk);
    hk(38, 1'b0);
    check("chatter", nc(), n + 1);
  endtask
  task automatic t_two(input int a, input int b, input logic [7:0] ea, input logic [7:0] eb);
    int n;
    n = nc();
    hk(a, 1'b1);
    hk(b, 1'b1);
    wc(n + 2);
    check("first code", cd(n), ea);
    check("second code", cd(n + 1), eb);
    keys[a] <= 1'b0;
    hk(b, 1'b0);
  endtask
  task automatic t_rep();
    int n, d, e;
    n = nc();
    keys[5] <= 1'b1;
    wc(n + 8);
    keys[5] <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      e = (i == 0) ? SS : (i == 6) ? FA : SL;
      d = kms_host_model_i.time_q[n + i + 1] - kms_host_model_i.time_q[n + i];
      check("repeat spacing", d >= e - 2 && d <= e + 2, 1'b1);
    end
    repeat (400) @(posedge clk);
    n = nc();
    repeat (800) @(posedge clk);
    check("repeat stop", nc(), n);
  endtask
  task automatic t_trk();
    for (int i = 0; i < 4; i++) begin
      trackball_in <= 4'h1 << i;
      // The strobe is launched five edges after the pin rises and stands for one cycle.
      repeat (5) @(posedge clk);
      @(negedge clk);
      check("trk strobe", trk_strobe, 1'b1);
      @(negedge clk);
      check("trk strobe end", trk_strobe, 1'b0);
      repeat (6) @(posedge clk);
      trackball_in <= 4'h0;
      repeat (12) @(posedge clk);
      check("trk dir", trk_dir, 4'h1 << i);
    end
  endtask
  task automatic t_fifo();
    int n;
    n = nc();
    kms_host_model_i.stall = 1'b1;
    for (int k = 24; k < 40; k++) hk(k, 1'b1);
    check("stalled", nc(), n);
    kms_host_model_i.stall = 1'b0;
    wc(n + 16);
    for (int k = 0; k < 16; k++) check("fifo order", cd(n + k), 8'(k + 24));
    keys <= '0;
    repeat (400) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_lamp();
    t_cmd();
    t_key();
    t_two(40, 50, 8'h28, 8'h32);
    t_two(0, 1, 8'h00, 8'h81);
    t_rep();
    t_trk();
    t_fifo();
    test_done();
  end
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
